// file: rtl/acsp_params.svh
// Constants for the configuration serial port: frame layout, map limits, defaults.
// Assumes inclusion by bare name from the design modules.
`ifndef ACSP_PARAMS_SVH
`define ACSP_PARAMS_SVH

// Header layout, logical order after assembly
`define ACSP_HDR_LAST_BIT   4'hF
`define ACSP_HDR_RW_BIT     15
`define ACSP_HDR_LEN_HI     14
`define ACSP_HDR_LEN_LO     13
`define ACSP_HDR_DEV_HI     12
`define ACSP_HDR_DEV_LO     10
`define ACSP_HDR_REG_HI     9
`define ACSP_BYTE_LAST_BIT  4'h7
`define ACSP_LEN_STREAM     2'h3
`define ACSP_DEV_FIXED_TOP  1'b0

// Register map limits
`define ACSP_ADDR_LAST      10'h15D
`define ACSP_ADDR_RO_FIRST  10'h15A
`define ACSP_ADDR_SAT       10'h3FF
`define ACSP_REG0_ADDR      10'h000
`define ACSP_MEM_DEPTH      512

// Mode register fields (mirrored nibbles) and default
`define ACSP_REG0_DEFAULT   8'h24
`define ACSP_F_SHUTDOWN_HI  7
`define ACSP_F_LSB_HI       6
`define ACSP_F_SOFTRST_HI   5
`define ACSP_F_STANDBY_HI   4
`define ACSP_F_STANDBY_LO   3
`define ACSP_F_SOFTRST_LO   2
`define ACSP_F_LSB_LO       1
`define ACSP_F_SHUTDOWN_LO  0

// Power-on delay before the defaults load, in device clock cycles
`define ACSP_POR_DELAY      1048576

`endif

// file: rtl/acsp_pkg.sv
// Types shared by the configuration serial port modules.
// Assumes acsp_params.svh is on the include path.
package acsp_pkg;
    typedef logic [9:0] acsp_addr_t;
    typedef logic [7:0] acsp_byte_t;
    typedef logic [8:0] acsp_mem_addr_t;

    typedef enum logic [6:0]
    {
        ST_POR  = 7'h01,
        ST_FILL = 7'h02,
        ST_IDLE = 7'h04,
        ST_HDR  = 7'h08,
        ST_WR   = 7'h10,
        ST_RD   = 7'h20,
        ST_SKIP = 7'h40
    } acsp_state_t;
endpackage

// file: rtl/acsp_regmem.sv
// Register storage: one write port, one read port with registered data.
// Assumes a single clock; contents are undefined until the port fills them.
`include "acsp_params.svh"

module acsp_regmem
(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // Write port
    input  wire logic                     wr_en,
    input  wire acsp_pkg::acsp_mem_addr_t wr_addr,
    input  wire acsp_pkg::acsp_byte_t     wr_data,
    // Read port
    input  wire acsp_pkg::acsp_mem_addr_t rd_addr,
    output acsp_pkg::acsp_byte_t          rd_data
);
    import acsp_pkg::*;

    acsp_byte_t mem [`ACSP_MEM_DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// file: rtl/acsp_port.sv
// Three-wire configuration port: frame decode, register storage, mode outputs.
// Assumes pins from outside the clk_sys domain; sclk well below clk_sys / 4.
//
// Operation
// - Chip select fall, then rising edge starts
// - Chip select high: ignore, data pin undriven
// - Chip select rise ends and abandons transfer
// - Sixteen-bit header then one or more bytes
// - Header direction bit: one reads, zero writes
// - Read drives pin after header; write never
// - Length code: one, two, three, or streaming
// - Device field: zero plus two select pins
// - Ten-bit field gives first register address
// - Each data byte is one register
// - Bit order from mode register, MSb default
// - Sample on rising edge, drive on falling
// - Address increments per byte, never wraps
// - Defaults load after delay or reset pin
// - Map spans 0x00 to 0x15D, sparse
// - Last four registers read-only, writes ignored
// - Mode register mirrored nibbles, default 0x24
`include "acsp_params.svh"

module acsp_port
#(
    parameter int unsigned POR_DELAY = `ACSP_POR_DELAY
)
(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // Serial pins
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sclk,
    input  wire logic                 sdio_in,
    output logic                      sdio_out,
    output logic                      sdio_oe,
    // Strap and reset pins
    input  wire logic                 addr_select_pin_hi,
    input  wire logic                 addr_select_pin_lo,
    input  wire logic                 hw_reset_n,
    // Read-only register contents, lowest address in the low byte
    input  wire logic [31:0]          ro_status,
    // Mode controls
    output logic                      cfg_shutdown,
    output logic                      cfg_standby,
    output logic                      cfg_soft_reset,
    output logic                      cfg_lsb_first,
    output logic                      cfg_ready,
    // Register write notification
    output logic                      cfg_wr_strobe,
    output acsp_pkg::acsp_addr_t      cfg_wr_addr,
    output acsp_pkg::acsp_byte_t      cfg_wr_data
);
    import acsp_pkg::*;

    function automatic acsp_addr_t addr_step(input acsp_addr_t a);
        addr_step = (a == `ACSP_ADDR_SAT) ? a : a + 10'h001;
    endfunction

    function automatic logic addr_writable(input acsp_addr_t a);
        addr_writable = (a < `ACSP_ADDR_RO_FIRST);
    endfunction

    function automatic acsp_byte_t default_of(input acsp_addr_t a);
        unique case (a)
            `ACSP_REG0_ADDR: default_of = `ACSP_REG0_DEFAULT;
            10'h001: default_of = 8'h0F;
            10'h004: default_of = 8'h9F;
            10'h007: default_of = 8'h62;
            10'h01E: default_of = 8'h80;
            10'h052: default_of = 8'h0A;
            10'h053: default_of = 8'h45;
            10'h055: default_of = 8'h48;
            10'h056: default_of = 8'h78;
            10'h057: default_of = 8'h40;
            10'h058: default_of = 8'h12;
            10'h059: default_of = 8'h41;
            10'h05A: default_of = 8'h2F;
            10'h05B, 10'h05C, 10'h05D: default_of = 8'h27;
            10'h05F: default_of = 8'hF1;
            10'h062: default_of = 8'h10;
            default: default_of = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0]  cs_sh_reg;
    logic [1:0]  sclk_sh_reg;
    logic [1:0]  sdi_sh_reg;
    logic [1:0]  hwr_sh_reg;
    logic [1:0]  adr_hi_sh_reg;
    logic [1:0]  adr_lo_sh_reg;
    logic        cs_d_reg;
    logic        sclk_d_reg;
    logic        hwr_d_reg;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_sh_reg     <= 2'h3;
            sclk_sh_reg   <= 2'h0;
            sdi_sh_reg    <= 2'h0;
            hwr_sh_reg    <= 2'h3;
            adr_hi_sh_reg <= 2'h0;
            adr_lo_sh_reg <= 2'h0;
            cs_d_reg      <= 1'b1;
            sclk_d_reg    <= 1'b0;
            hwr_d_reg     <= 1'b1;
        end
        else
        begin
            cs_sh_reg     <= {cs_sh_reg[0], spi_cs_n};
            sclk_sh_reg   <= {sclk_sh_reg[0], spi_sclk};
            sdi_sh_reg    <= {sdi_sh_reg[0], sdio_in};
            hwr_sh_reg    <= {hwr_sh_reg[0], hw_reset_n};
            adr_hi_sh_reg <= {adr_hi_sh_reg[0], addr_select_pin_hi};
            adr_lo_sh_reg <= {adr_lo_sh_reg[0], addr_select_pin_lo};
            cs_d_reg      <= cs_sh_reg[1];
            sclk_d_reg    <= sclk_sh_reg[1];
            hwr_d_reg     <= hwr_sh_reg[1];
        end
    end

    wire cs_high   = cs_sh_reg[1];
    wire cs_fall   = cs_d_reg & ~cs_sh_reg[1];
    wire sclk_rise = sclk_sh_reg[1] & ~sclk_d_reg;
    wire sclk_fall = sclk_d_reg & ~sclk_sh_reg[1];
    wire sdi_bit   = sdi_sh_reg[1];
    wire hwr_rise  = hwr_sh_reg[1] & ~hwr_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame state and decode
    acsp_state_t state_reg;
    acsp_state_t state_next;
    logic [20:0] por_cnt_reg;
    acsp_addr_t  fill_addr_reg;
    logic [15:0] hdr_reg;
    logic [3:0]  bitcnt_reg;
    acsp_byte_t  rx_reg;
    acsp_byte_t  tx_reg;
    logic [2:0]  tx_cnt_reg;
    acsp_addr_t  addr_reg;
    logic [1:0]  len_reg;
    logic [1:0]  bytes_reg;
    acsp_byte_t  reg0_reg;
    logic        sdo_reg;
    logic        oe_reg;
    acsp_byte_t  mem_rdata;

    wire in_data    = (state_reg == ST_WR) || (state_reg == ST_RD);
    wire in_frame   = in_data || (state_reg == ST_HDR) || (state_reg == ST_SKIP);
    wire fill_on    = (state_reg == ST_FILL);
    wire por_done   = (por_cnt_reg == 21'(POR_DELAY - 1));
    wire lsb_first  = reg0_reg[`ACSP_F_LSB_HI] | reg0_reg[`ACSP_F_LSB_LO];

    // Header uses the data bit order
    wire [15:0] hdr_next = lsb_first ? {sdi_bit, hdr_reg[15:1]} : {hdr_reg[14:0], sdi_bit};
    wire [7:0]  rx_next  = lsb_first ? {sdi_bit, rx_reg[7:1]} : {rx_reg[6:0], sdi_bit};

    // Sixteen rising edges make the header
    wire hdr_done  = (state_reg == ST_HDR) && sclk_rise && (bitcnt_reg == `ACSP_HDR_LAST_BIT);
    // Eight rising edges make one register byte
    wire byte_done = in_data && sclk_rise && (bitcnt_reg == `ACSP_BYTE_LAST_BIT);
    // Fixed top bit plus strap levels
    wire [2:0] own_dev = {`ACSP_DEV_FIXED_TOP, adr_hi_sh_reg[1], adr_lo_sh_reg[1]};
    wire hdr_match = (hdr_next[`ACSP_HDR_DEV_HI:`ACSP_HDR_DEV_LO] == own_dev);
    // Fixed lengths end after len+1 bytes
    wire last_byte = (len_reg != `ACSP_LEN_STREAM) && (bytes_reg == len_reg);

    // Frame opens on select fall, closes on rise
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POR:  if (por_done) state_next = ST_FILL;
            ST_FILL: if (fill_addr_reg == `ACSP_ADDR_LAST) state_next = ST_IDLE;
            ST_IDLE: if (cs_fall) state_next = ST_HDR;
            ST_HDR:
            begin
                if (cs_high) state_next = ST_IDLE;
                // Direction bit picks read or write
                else if (hdr_done) state_next = !hdr_match ? ST_SKIP :
                                                hdr_next[`ACSP_HDR_RW_BIT] ? ST_RD : ST_WR;
            end
            ST_WR, ST_RD:
            begin
                if (cs_high) state_next = ST_IDLE;
                else if (byte_done && last_byte) state_next = ST_SKIP;
            end
            ST_SKIP: if (cs_high) state_next = ST_IDLE;
        endcase
        if (hwr_rise) state_next = ST_FILL;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg   <= ST_POR;
            por_cnt_reg <= 21'h000000;
        end
        else
        begin
            state_reg   <= state_next;
            por_cnt_reg <= (state_reg == ST_POR) ? por_cnt_reg + 21'h000001 : 21'h000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift registers and address counter
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hdr_reg    <= 16'h0000;
            rx_reg     <= 8'h00;
            bitcnt_reg <= 4'h0;
            addr_reg   <= 10'h000;
            len_reg    <= 2'h0;
            bytes_reg  <= 2'h0;
        end
        else if (!in_frame)
        begin
            bitcnt_reg <= 4'h0;
            bytes_reg  <= 2'h0;
        end
        else if (sclk_rise)
        begin
            hdr_reg    <= hdr_next;
            rx_reg     <= rx_next;
            bitcnt_reg <= (hdr_done || byte_done) ? 4'h0 : bitcnt_reg + 4'h1;
            if (hdr_done)
            begin
                addr_reg <= hdr_next[`ACSP_HDR_REG_HI:0];
                len_reg  <= hdr_next[`ACSP_HDR_LEN_HI:`ACSP_HDR_LEN_LO];
            end
            if (byte_done)
            begin
                // Step address, saturate instead of wrapping
                addr_reg  <= addr_step(addr_reg);
                bytes_reg <= bytes_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and write path
    // Read-only tail rejects writes
    wire        wr_hit    = (state_reg == ST_WR) && byte_done && addr_writable(addr_reg);
    wire        mem_we    = fill_on || wr_hit;
    wire [9:0]  mem_waddr = fill_on ? fill_addr_reg : addr_reg;
    wire [7:0]  mem_wdata = fill_on ? default_of(fill_addr_reg) : rx_next;
    // Addresses past the map read zero
    wire        ro_hit    = !addr_writable(addr_reg) && (addr_reg <= `ACSP_ADDR_LAST);
    wire [1:0]  ro_sel    = 2'(addr_reg - `ACSP_ADDR_RO_FIRST);
    wire [7:0]  ro_byte   = ro_status[{ro_sel, 3'h0} +: 8];
    wire [7:0]  rd_word   = ro_hit ? ro_byte : (addr_reg <= `ACSP_ADDR_LAST) ? mem_rdata : 8'h00;

    acsp_regmem u_regmem
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr[8:0]),
        .wr_data (mem_wdata),
        .rd_addr (addr_reg[8:0]),
        .rd_data (mem_rdata)
    );

    // Fill walks the whole map with defaults
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fill_addr_reg <= 10'h000;
            reg0_reg      <= `ACSP_REG0_DEFAULT;
            cfg_wr_strobe <= 1'b0;
            cfg_wr_addr   <= 10'h000;
            cfg_wr_data   <= 8'h00;
        end
        else
        begin
            fill_addr_reg <= fill_on ? addr_step(fill_addr_reg) : 10'h000;
            if (mem_we && (mem_waddr == `ACSP_REG0_ADDR))
            begin
                reg0_reg <= mem_wdata;
            end
            cfg_wr_strobe <= wr_hit;
            cfg_wr_addr   <= wr_hit ? addr_reg : cfg_wr_addr;
            cfg_wr_data   <= wr_hit ? rx_next : cfg_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read output path
    wire [7:0] tx_src = (tx_cnt_reg == 3'h0) ? rd_word : tx_reg;

    // Output bits change on falling edges only
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_reg     <= 8'h00;
            tx_cnt_reg <= 3'h0;
            sdo_reg    <= 1'b0;
        end
        else if (state_reg != ST_RD)
        begin
            tx_cnt_reg <= 3'h0;
        end
        else if (sclk_fall)
        begin
            sdo_reg    <= lsb_first ? tx_src[0] : tx_src[7];
            tx_reg     <= lsb_first ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
        end
    end

    // Pin turns around on first fall after header
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            oe_reg <= 1'b0;
        end
        else
        begin
            oe_reg <= (state_next == ST_RD) && (oe_reg || sclk_fall);
        end
    end

    assign sdio_out       = sdo_reg;
    assign sdio_oe        = oe_reg;
    assign cfg_lsb_first  = lsb_first;
    assign cfg_shutdown   = reg0_reg[`ACSP_F_SHUTDOWN_HI] | reg0_reg[`ACSP_F_SHUTDOWN_LO];
    assign cfg_standby    = reg0_reg[`ACSP_F_STANDBY_HI] | reg0_reg[`ACSP_F_STANDBY_LO];
    assign cfg_soft_reset = ~reg0_reg[`ACSP_F_SOFTRST_HI] | ~reg0_reg[`ACSP_F_SOFTRST_LO];
    assign cfg_ready      = (state_reg != ST_POR) && !fill_on;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    cs_release_hiz_a: assert property (cs_high |=> !sdio_oe)
        else $error("data pin driven after chip select rose");
    cs_abort_frame_a: assert property (cs_high && in_frame && !hwr_rise |=> state_reg == ST_IDLE)
        else $error("frame not abandoned on chip select rise");
    hdr_no_drive_a: assert property ((state_reg == ST_HDR) || (state_reg == ST_WR) |-> !sdio_oe)
        else $error("data pin driven during header or write");
    read_select_a: assert property (hdr_done && hdr_match && hdr_next[15] && !cs_high && !hwr_rise
                                    |=> state_reg == ST_RD)
        else $error("read header did not enter read");
    dev_mismatch_a: assert property (hdr_done && !hdr_match && !cs_high && !hwr_rise
                                     |=> state_reg == ST_SKIP ##1 !sdio_oe)
        else $error("foreign header was acted on");
    addr_step_a: assert property (byte_done && (addr_reg != 10'h3FF) |=> addr_reg == $past(addr_reg) + 10'h001)
        else $error("address did not step by one");
    ro_protect_a: assert property (mem_we && !fill_on |-> mem_waddr < 10'h15A)
        else $error("write reached read-only register");
    sdo_on_fall_a: assert property ($changed(sdio_out) |-> $past(sclk_fall))
        else $error("output bit changed off a falling edge");
    single_byte_a: assert property (byte_done && (len_reg == 2'h0) && !cs_high && !hwr_rise
                                    |=> state_reg == ST_SKIP)
        else $error("one-byte frame kept going");
    hdr_complete_a: assert property ($rose(state_reg == ST_WR) |-> $past(bitcnt_reg) == 4'hF)
        else $error("write began before full header");
    por_fill_a: assert property ((state_reg == ST_POR) && por_done |=> state_reg == ST_FILL)
        else $error("defaults not loaded after power-on delay");
endmodule

// file: test/acsp_host.sv
// Host model for the configuration serial port: drives chip select, clock and data.
// Assumes the bench loads tx before each frame call and reads rx and oe_seen after it.
module acsp_host
(
    // Serial pins
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      sdio_in,
    // Device side of the data pin
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       h_oe = 1'b0;
    logic       h_val = 1'b0;
    logic       line = 1'b0;
    logic [7:0] tx [0:7];
    logic [7:0] rx [0:7];
    bit         oe_seen;
    int         hp = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // Released line shows the inverse of its last level
    always @(sdio_oe, sdio_out, h_oe, h_val)
    begin
        if (sdio_oe === 1'b1)
            line = sdio_out;
        else if (h_oe)
            line = h_val;
        else
            line = ~line;
    end
    assign sdio_in = line;

    always @(posedge sdio_oe)
        oe_seen = 1'b1;

    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive while low, sample at the rising edge
    task automatic shift(input logic [15:0] v, input int nb, input bit lsb, input bit drv, output logic [15:0] got);
        int idx;
        got = '0;
        for (int i = 0; i < nb; i++)
        begin
            idx = lsb ? i : nb - 1 - i;
            spi_sclk = 1'b0;
            if (drv)
                h_val = v[idx];
            h_oe = drv;
            #hp;
            got[idx] = line;
            spi_sclk = 1'b1;
            #hp;
        end
    endtask

    // Select held over header and bytes
    task automatic frame(input logic [15:0] hdr, input int n, input bit lsb, input int extra);
        logic [15:0] g;
        oe_seen = 1'b0;
        spi_cs_n = 1'b0;
        #hp;
        shift(hdr, 16, lsb, 1'b1, g);
        for (int k = 0; k < n + int'(extra > 0); k++)
        begin
            shift({8'h00, tx[k]}, (k < n) ? 8 : extra, lsb, !hdr[15], g);
            rx[k] = g[7:0];
        end
        #hp;
        h_oe = 1'b0;
        spi_cs_n = 1'b1;
        #hp;
        spi_sclk = 1'b0;
        #(4 * hp);
    endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the configuration serial port driven by a host model.
// Assumes the design files and acsp_host are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import acsp_pkg::*;

    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hw_reset_n = 1'b1;
    logic        addr_select_pin_hi = 1'b0;
    logic        addr_select_pin_lo = 1'b0;
    logic [31:0] ro_status = '0;
    logic        spi_cs_n, spi_sclk, sdio_in, sdio_out, sdio_oe;
    logic        cfg_shutdown, cfg_standby, cfg_soft_reset, cfg_lsb_first, cfg_ready, cfg_wr_strobe;
    acsp_addr_t  cfg_wr_addr;
    acsp_byte_t  cfg_wr_data;
    int          fails = 0;
    int          tests_run = 0;
    int          hi_cnt = 0;
    logic [7:0]  ref_mem [int];
    bit          lsb_m;
    logic [2:0]  dev;
    acsp_addr_t  wa_q [$];
    acsp_byte_t  wd_q [$];

    acsp_port #(.POR_DELAY(16)) u_dut
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .addr_select_pin_hi(addr_select_pin_hi), .addr_select_pin_lo(addr_select_pin_lo),
        .hw_reset_n(hw_reset_n), .ro_status(ro_status), .cfg_shutdown(cfg_shutdown),
        .cfg_standby(cfg_standby), .cfg_soft_reset(cfg_soft_reset), .cfg_lsb_first(cfg_lsb_first),
        .cfg_ready(cfg_ready), .cfg_wr_strobe(cfg_wr_strobe), .cfg_wr_addr(cfg_wr_addr),
        .cfg_wr_data(cfg_wr_data)
    );

    acsp_host u_host
    (
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe)
    );

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            fails++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(negedge clk_sys)
    begin
        if (cfg_wr_strobe === 1'b1)
        begin
            wa_q.push_back(cfg_wr_addr);
            wd_q.push_back(cfg_wr_data);
        end
        hi_cnt = spi_cs_n ? hi_cnt + 1 : 0;
        if (hi_cnt > 8)
            chk(sdio_oe === 1'b0, "data pin driven while deselected");
    end

    function automatic logic [8:0] exp_rd(input int a);
        if (a >= 'h15A && a <= 'h15D)
            return {1'b1, ro_status[(a - 'h15A) * 8 +: 8]};
        if (a > 'h15D || ref_mem.exists(a))
            return {1'b1, (a > 'h15D) ? 8'h00 : ref_mem[a]};
        return 9'h000;
    endfunction

    task automatic wait_ready();
        int t;
        t = 0;
        while (cfg_ready !== 1'b1 && t < 2000)
        begin
            @(negedge clk_sys);
            t++;
        end
        chk(cfg_ready === 1'b1, "ready after defaults load");
    endtask

    // One frame, then compare strobes or read bytes with the reference
    task automatic xact(input bit rd, input logic [1:0] len, input logic [2:0] dv, input int a, input int n,
                        input int extra, input int d0);
        logic [8:0] e;
        int         eff;
        int         cnt;
        bit         hit;
        hit = (dv === {1'b0, addr_select_pin_hi, addr_select_pin_lo});
        eff = hit ? ((len == 2'h3 || n < len + 1) ? n : len + 1) : 0;
        cnt = 0;
        for (int k = 0; k < 8; k++)
            u_host.tx[k] = 8'($urandom);
        if (d0 >= 0)
            u_host.tx[0] = d0[7:0];
        wa_q.delete();
        wd_q.delete();
        u_host.frame({rd, len, dv, a[9:0]}, n, lsb_m, extra);
        repeat (10) @(negedge clk_sys);
        chk(u_host.oe_seen == (rd && hit), "data pin direction");
        for (int k = 0; k < eff; k++)
        begin
            e = exp_rd(a + k);
            if (rd && e[8])
                chk(u_host.rx[k] === e[7:0], "read data");
            else if (!rd && a + k <= 'h159)
            begin
                chk(wa_q.size() > cnt && wa_q[cnt] === a + k && wd_q[cnt] === u_host.tx[k], "write strobe");
                ref_mem[a + k] = u_host.tx[k];
                lsb_m = (a + k == 0) ? (u_host.tx[k][6] | u_host.tx[k][1]) : lsb_m;
                cnt++;
            end
        end
        chk(rd || wa_q.size() == cnt, "write count");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int a;
        int seed_ret;
        seed_ret = $urandom(32'hAB25835F);
        addr_select_pin_hi = 1'($urandom);
        addr_select_pin_lo = 1'($urandom);
        ro_status = $urandom;
        dev = {1'b0, addr_select_pin_hi, addr_select_pin_lo};
        ref_mem[0] = 8'h24;
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        wait_ready();
        chk(cfg_soft_reset === 1'b0 && cfg_shutdown === 1'b0 && cfg_standby === 1'b0 && cfg_lsb_first === 1'b0,
            "mode defaults");
        xact(1'b1, 2'h0, dev, 0, 1, 0, -1);
        repeat (2)
            for (int len = 0; len < 4; len++)
            begin
                // Random starts stay inside the map
                a = 1 + $urandom_range(32'h150);
                xact(1'b0, len[1:0], dev, a, len + 2, 0, -1);
                xact(1'b1, len[1:0], dev, a, len + 2, 0, -1);
            end
        xact(1'b0, 2'h3, dev, 'h158, 6, 0, -1);
        xact(1'b1, 2'h3, dev, 'h158, 6, 0, -1);
        xact(1'b1, 2'h3, dev, 'h15C, 4, 0, -1);
        xact(1'b0, 2'h0, dev ^ 3'h4, 'h20, 1, 0, -1);
        xact(1'b1, 2'h0, dev ^ 3'h1, 'h20, 1, 0, -1);
        xact(1'b0, 2'h1, dev, 'h30, 1, 3, -1);
        xact(1'b0, 2'h0, dev, 0, 1, 0, 'h66);
        chk(cfg_lsb_first === 1'b1, "bit order select");
        xact(1'b0, 2'h2, dev, 'h40, 3, 0, -1);
        xact(1'b1, 2'h2, dev, 'h40, 3, 0, -1);
        xact(1'b0, 2'h0, dev, 0, 1, 0, 'h25);
        chk(cfg_lsb_first === 1'b0 && cfg_shutdown === 1'b1, "mode register write");
        xact(1'b0, 2'h0, dev, 0, 1, 0, 'h08);
        chk(cfg_standby === 1'b1 && cfg_soft_reset === 1'b1 && cfg_shutdown === 1'b0, "standby and soft reset");
        hw_reset_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        hw_reset_n = 1'b1;
        repeat (20) @(negedge clk_sys);
        chk(cfg_ready === 1'b0, "reload in progress");
        wait_ready();
        ref_mem.delete();
        ref_mem[0] = 8'h24;
        lsb_m = 1'b0;
        chk(cfg_shutdown === 1'b0 && cfg_standby === 1'b0 && cfg_soft_reset === 1'b0, "defaults after reset pin");
        xact(1'b1, 2'h0, dev, 0, 1, 0, -1);
        give_verdict();
    end

    initial
    begin
        #400us;
        fails++;
        $display("Error at %0t ns: watchdog expired", $time);
        give_verdict();
    end
endmodule
